// ===== adc_pair_trig_pkg.sv
// Package for the paired conversion trigger control block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
package adc_pair_trig_pkg;
   localparam int NUM_PAIRS = 3;
   localparam int SEL_W = 5;
   // Byte offsets of the registers
   localparam logic [3:0] OFF_CTRL_A = 4'h0;
   localparam logic [3:0] OFF_CTRL_B = 4'h4;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
   // Field positions inside one byte lane of a control register
   localparam int POS_SEL = 0;
   localparam int POS_SWTRG = 5;
   localparam int POS_PEND = 6;
   localparam int POS_IRQEN = 7;
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [2:0] MASK_RESET = 3'h0;
   // Trigger selector codes
   localparam logic [4:0] SEL_NONE = 5'h00;
   localparam logic [4:0] SEL_SOFT = 5'h01;
   localparam logic [4:0] SEL_GLOBAL = 5'h02;
   localparam logic [4:0] SEL_SPECIAL = 5'h03;
   localparam logic [4:0] SEL_PWM_FIRST = 5'h04;
   localparam logic [4:0] SEL_PWM_LAST = 5'h07;
   localparam logic [4:0] SEL_TMR1 = 5'h0C;
   localparam logic [4:0] SEL_TMR2 = 5'h0D;
   localparam logic [4:0] SEL_CL_FIRST = 5'h0E;
   localparam logic [4:0] SEL_CL_LAST = 5'h11;
   localparam logic [4:0] SEL_FLT_FIRST = 5'h16;
   localparam logic [4:0] SEL_FLT_LAST = 5'h19;
   // Pair conversion state
   typedef enum logic [1:0] {
      PAIR_IDLE = 2'b00,
      PAIR_PEND = 2'b01,
      PAIR_CONV = 2'b11
   } pair_state_e;
endpackage

// ===== adc_pair_trigger_control.sv
// Trigger selection, pending status and interrupt for three conversion pairs.
// Assumes trigger pulses and the conversion core handshake are synchronous to clock_i.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

// How it works
// - Selector zero never starts a conversion
// - Code 1 own soft, code 2 global soft
// - Code 3 special event, 4-7 PWM generators
// - Codes 12, 13 timer one, two period match
// - Codes 14-17 PWM current-limit triggers
// - Codes 22-25 PWM fault triggers
// - Register A bits 4-0 select pair two
// - Register B bits 12-8 select pair five
// - Upper byte: irq enable, pending, soft, selector
// - Lower byte: irq enable, pending, soft, selector
// - Bit 15 enables pair five completion irq
// - Bit 7 enables pair four completion irq
// - Pair five pending sets on trigger, clears done
// - Pair four pending sets on trigger, clears done
// - Soft bit honoured only with soft selector
// - Busy core holds soft request until free
// - Soft bit clears when pending sets
// - Register B read/write, resets to zero
module adc_pair_trigger_control #(
   parameter int NP = adc_pair_trig_pkg::NUM_PAIRS
) (
   input wire logic clock_i, // System clock
   input wire logic reset_i, // Synchronous reset, active high
   input wire logic enable_i, // Clock enable, freezes state when low
   input wire logic [3:0] avs_address_i, // Byte address
   input wire logic avs_read_i, // Read strobe
   input wire logic avs_write_i, // Write strobe
   input wire logic [31:0] avs_writedata_i, // Write data
   input wire logic [3:0] avs_byteenable_i, // Byte enables
   output logic [31:0] avs_readdata_o, // Read data
   output logic avs_waitrequest_o, // Wait request
   input wire logic global_soft_trig_i, // Shared software trigger pulse
   input wire logic special_event_trig_i, // PWM special event trigger pulse
   input wire logic [3:0] pwm_trig_i, // PWM generator triggers 1-4
   input wire logic [1:0] timer_period_i, // Timer 1 and 2 period match
   input wire logic [3:0] pwm_climit_trig_i, // PWM current-limit triggers 1-4
   input wire logic [3:0] pwm_fault_trig_i, // PWM fault triggers 1-4
   output logic [NP-1:0] conv_req_o, // Conversion request per pair
   input wire logic [NP-1:0] conv_grant_i, // Core accepts the pair's request
   input wire logic [NP-1:0] conv_done_i, // Core finished the pair's conversion
   output logic irq_o // Level interrupt
);

   typedef adc_pair_trig_pkg::pair_state_e pair_state_e_t;

   // Pair 0 = register A bits 7..0 (pair two); pairs 1, 2 = B low and high (four, five)
   typedef struct packed {
      logic [NP-1:0][7:0] ctrl;
      pair_state_e_t [NP-1:0] st;
      logic [NP-1:0] status;
      logic [NP-1:0] mask;
      logic [31:0] rdata;
      logic ack;
   } state_s;

   state_s cur_r;
   state_s cur_nxt;

   // One decoder for every pair; unassigned codes return no trigger
   function automatic logic trig_sel(input logic [4:0] sel, input logic own_soft,
                                     input logic glob, input logic spec,
                                     input logic [3:0] pwm, input logic [1:0] tmr,
                                     input logic [3:0] cl, input logic [3:0] flt);
      logic hit;
      hit = 1'b0;
      if (sel == adc_pair_trig_pkg::SEL_SOFT) begin
         hit = own_soft;
      end else if (sel == adc_pair_trig_pkg::SEL_GLOBAL) begin
         hit = glob;
      end else if (sel == adc_pair_trig_pkg::SEL_SPECIAL) begin
         hit = spec;
      end else if (sel >= adc_pair_trig_pkg::SEL_PWM_FIRST &&
                   sel <= adc_pair_trig_pkg::SEL_PWM_LAST) begin
         hit = pwm[sel[1:0]];
      end else if (sel == adc_pair_trig_pkg::SEL_TMR1) begin
         hit = tmr[0];
      end else if (sel == adc_pair_trig_pkg::SEL_TMR2) begin
         hit = tmr[1];
      end else if (sel >= adc_pair_trig_pkg::SEL_CL_FIRST &&
                   sel <= adc_pair_trig_pkg::SEL_CL_LAST) begin
         hit = cl[2'(sel - adc_pair_trig_pkg::SEL_CL_FIRST)];
      end else if (sel >= adc_pair_trig_pkg::SEL_FLT_FIRST &&
                   sel <= adc_pair_trig_pkg::SEL_FLT_LAST) begin
         hit = flt[2'(sel - adc_pair_trig_pkg::SEL_FLT_FIRST)];
      end
      // Code zero and the gaps fall through with no trigger
      return hit;
   endfunction

   // Merge a byte lane of a write under its enable
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] wd,
                                       input logic be);
      return be ? wd : old;
   endfunction

   logic [NP-1:0] trig;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] wb [NP];
   logic [NP-1:0] wen;

   always_comb begin
      wr_hit = avs_write_i && !cur_r.ack;
      rd_hit = avs_read_i && !cur_r.ack;
      // Byte image and enable for each pair's control byte
      wb[0] = avs_writedata_i[7:0];
      wen[0] = wr_hit && avs_address_i == adc_pair_trig_pkg::OFF_CTRL_A && avs_byteenable_i[0];
      wb[1] = avs_writedata_i[7:0];
      wen[1] = wr_hit && avs_address_i == adc_pair_trig_pkg::OFF_CTRL_B && avs_byteenable_i[0];
      wb[2] = avs_writedata_i[15:8];
      wen[2] = wr_hit && avs_address_i == adc_pair_trig_pkg::OFF_CTRL_B && avs_byteenable_i[1];
      for (int p = 0; p < NP; p++) begin
         trig[p] = trig_sel(cur_r.ctrl[p][4:0],
                            cur_r.ctrl[p][adc_pair_trig_pkg::POS_SWTRG],
                            global_soft_trig_i, special_event_trig_i, pwm_trig_i,
                            timer_period_i, pwm_climit_trig_i, pwm_fault_trig_i);
      end
   end

   always_comb begin
      logic [7:0] c;
      c = 8'h00;
      cur_nxt = cur_r;
      // Read data stands until the next accepted read
      cur_nxt.ack = (avs_read_i || avs_write_i) && !cur_r.ack;
      for (int p = 0; p < NP; p++) begin
         c = cur_r.ctrl[p];
         if (wen[p]) begin
            c = lane(c, wb[p], 1'b1);
            // Pending reflects hardware; software writes to it are ignored
            c[adc_pair_trig_pkg::POS_PEND] = cur_r.ctrl[p][adc_pair_trig_pkg::POS_PEND];
         end
         unique case (cur_r.st[p])
            adc_pair_trig_pkg::PAIR_IDLE: begin
               if (trig[p]) begin
                  c[adc_pair_trig_pkg::POS_PEND] = 1'b1;
                  c[adc_pair_trig_pkg::POS_SWTRG] = 1'b0;
                  cur_nxt.st[p] = adc_pair_trig_pkg::PAIR_PEND;
               end
            end
            adc_pair_trig_pkg::PAIR_PEND: begin
               // Request waits here while the core serves others
               if (conv_grant_i[p]) begin
                  cur_nxt.st[p] = adc_pair_trig_pkg::PAIR_CONV;
               end
            end
            adc_pair_trig_pkg::PAIR_CONV: begin
               if (conv_done_i[p]) begin
                  c[adc_pair_trig_pkg::POS_PEND] = 1'b0;
                  cur_nxt.st[p] = adc_pair_trig_pkg::PAIR_IDLE;
               end
            end
            default: cur_nxt.st[p] = adc_pair_trig_pkg::PAIR_IDLE;
         endcase
         // A soft bit left under a non-soft selector is never honoured
         if (cur_r.ctrl[p][4:0] != adc_pair_trig_pkg::SEL_SOFT) begin
            c[adc_pair_trig_pkg::POS_SWTRG] = c[adc_pair_trig_pkg::POS_SWTRG];
         end
         cur_nxt.ctrl[p] = c;
      end
      // Sticky completion status, write one to clear, set wins
      if (wr_hit && avs_address_i == adc_pair_trig_pkg::OFF_IRQ_STATUS && avs_byteenable_i[0]) begin
         cur_nxt.status = cur_r.status & ~avs_writedata_i[NP-1:0];
      end
      if (wr_hit && avs_address_i == adc_pair_trig_pkg::OFF_IRQ_MASK && avs_byteenable_i[0]) begin
         cur_nxt.mask = avs_writedata_i[NP-1:0];
      end
      for (int p = 0; p < NP; p++) begin
         if (cur_r.st[p] == adc_pair_trig_pkg::PAIR_CONV && conv_done_i[p] &&
             cur_r.ctrl[p][adc_pair_trig_pkg::POS_IRQEN]) begin
            cur_nxt.status[p] = 1'b1;
         end
      end
      if (rd_hit) begin
         unique case (avs_address_i)
            adc_pair_trig_pkg::OFF_CTRL_A: cur_nxt.rdata = {24'h000000, cur_r.ctrl[0]};
            adc_pair_trig_pkg::OFF_CTRL_B: cur_nxt.rdata = {16'h0000, cur_r.ctrl[2],
                                                              cur_r.ctrl[1]};
            adc_pair_trig_pkg::OFF_IRQ_STATUS: cur_nxt.rdata = 32'(cur_r.status);
            adc_pair_trig_pkg::OFF_IRQ_MASK: cur_nxt.rdata = 32'(cur_r.mask);
            default: cur_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int p = 0; p < NP; p++) begin
            cur_r.ctrl[p] <= 8'h00;
            cur_r.st[p] <= adc_pair_trig_pkg::PAIR_IDLE;
         end
         cur_r.status <= '0;
         cur_r.mask <= '0;
         cur_r.rdata <= 32'h0000_0000;
         cur_r.ack <= 1'b0;
      end else if (enable_i) begin
         cur_r <= cur_nxt;
      end
   end

   always_comb begin
      avs_readdata_o = cur_r.rdata;
      avs_waitrequest_o = (avs_read_i || avs_write_i) && !cur_r.ack;
      irq_o = |(cur_r.status & cur_r.mask);
      for (int p = 0; p < NP; p++) begin
         conv_req_o[p] = cur_r.st[p] == adc_pair_trig_pkg::PAIR_PEND;
      end
   end

endmodule // adc_pair_trigger_control

// ===== adc_pair_trigger_control_monitor.sv
// Port checker for adc_pair_trigger_control.
// Bound into the design; its inputs follow the design's port names.
`timescale 1ns/1ps
module adc_pair_trigger_monitor #(
   parameter int NP = 3
) (
   input wire logic clock_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic enable_i, // Run
   input wire logic avs_read_i, // Read
   input wire logic avs_write_i, // Write
   input wire logic [31:0] avs_readdata_o, // Data
   input wire logic avs_waitrequest_o, // Stall
   input wire logic [NP-1:0] conv_req_o, // Request
   input wire logic [NP-1:0] conv_grant_i, // Grant
   input wire logic [NP-1:0] conv_done_i, // Done
   input wire logic irq_o // Interrupt
);
   wire logic rq = avs_read_i | avs_write_i;
   wire logic [NP-1:0] wt = conv_req_o & ~conv_grant_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_wait_first: assert property (rq && !$past(rq) |-> avs_waitrequest_o)
      else $error("no stall on new request");
   a_wait_answer: assert property (rq && avs_waitrequest_o && enable_i |=>
      !avs_waitrequest_o || !enable_i) else $error("no answer after stall");
   a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |->
      avs_readdata_o[31:16] == 16'h0000) else $error("upper half not zero");
   a_reset_quiet: assert property ($past(reset_i) |-> !irq_o && conv_req_o == '0)
      else $error("outputs not cleared by reset");
   a_req_hold: assert property (!$past(reset_i) && $past(enable_i) |->
      (conv_req_o & $past(wt)) == $past(wt)) else $error("request dropped early");
   a_grant_drops: assert property (!$past(reset_i) && $past(enable_i) |->
      (conv_req_o & $past(conv_grant_i)) == '0) else $error("request after grant");
   a_irq_cause: assert property ($rose(irq_o) |->
      $past(conv_done_i) != '0 || $past(avs_write_i)) else $error("irq without cause");
   a_irq_fall: assert property (!$past(reset_i) && $fell(irq_o) |->
      $past(avs_write_i)) else $error("irq fell without write");
   c_irq: cover property ($rose(irq_o));
   c_grant: cover property ((conv_grant_i & conv_req_o) != '0);
   c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule // adc_pair_trigger_monitor
bind adc_pair_trigger_control adc_pair_trigger_monitor #(.NP(NP)) i_adc_pair_trigger_monitor (.*);

// ===== conv_core_model.sv
// Behavioural shared conversion core serving one pair at a time.
// Requests are levels; grant and done are one-cycle pulses.
`timescale 1ns/1ps
module conv_core_model (
   input wire logic clock_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic [2:0] lat_i, // Wait cycles
   input wire logic [2:0] req_i, // Requests
   output logic [2:0] grant_o = 3'h0, // Start pulses
   output logic [2:0] done_o = 3'h0 // Done pulses
);
   int st;
   int cnt;
   logic [2:0] cur;
   // One pair at a time, so the others stay queued while busy
   always @(posedge clock_i) begin
      grant_o <= 3'h0;
      done_o <= 3'h0;
      if (reset_i) begin
         st = 0;
         cnt = 0;
      end else if (cnt > 0) begin
         cnt--;
      end else if (st == 0 && req_i != 3'h0) begin
         cur = req_i & -req_i;
         cnt = lat_i;
         st = 1;
      end else if (st == 1) begin
         grant_o <= cur;
         cnt = lat_i + 2;
         st = 2;
      end else if (st == 2) begin
         done_o <= cur;
         st = 0;
      end
   end
endmodule // conv_core_model

// ===== test_adc_pair_trigger_control.sv
// Self-checking bench for adc_pair_trigger_control.
// Avalon-MM master, trigger pulses and a model core; expectations from a local model.
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %0h seen %0h", n, e, s); end end
`define TRG {pwm_fault_trig_i, pwm_climit_trig_i, timer_period_i, pwm_trig_i, \
   special_event_trig_i, global_soft_trig_i}
module test_adc_pair_trigger_control;
   logic clock_i = 1'b0, reset_i = 1'b1, enable_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic global_soft_trig_i = 1'b0, special_event_trig_i = 1'b0, avs_waitrequest_o, irq_o;
   logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h0, pwm_trig_i = 4'h0;
   logic [3:0] pwm_climit_trig_i = 4'h0, pwm_fault_trig_i = 4'h0;
   logic [1:0] timer_period_i = 2'h0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
   logic [2:0] lat = 3'h0, conv_req_o, conv_grant_i, conv_done_i;
   int fail_count = 0, total_checks = 0, regs[3], dcnt[3], d0[3];
   adc_pair_trigger_control i_adc_pair_trigger_control (.*);
   conv_core_model i_conv_core_model (.clock_i, .reset_i, .lat_i(lat), .req_i(conv_req_o),
      .grant_o(conv_grant_i), .done_o(conv_done_i));
   initial forever #5 clock_i = ~clock_i;
   always @(posedge clock_i) for (int q = 0; q < 3; q++) dcnt[q] += conv_done_i[q] === 1'b1;
   task automatic stop_test;
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      // Look at settled values mid-cycle, release only after the answering edge
      do begin
         @(negedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 40);
      rd = avs_readdata_o;
      @(posedge clock_i);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n >= 40) begin
         fail_count++;
         stop_test();
      end
      @(posedge clock_i);
   endtask
   // Source bit in the TRG vector, -1 for code 1 (own soft) and where the code starts nothing
   function automatic int pick(int c);
      if (c >= 2 && c <= 7) return c - 2;
      if (c >= 12 && c <= 17) return c - 6;
      if (c >= 22 && c <= 25) return c - 10;
      return -1;
   endfunction
   function automatic logic [31:0] ctrl(int p, int pm);
      if (p == 0) return 32'(regs[0] | (pm & 1) << 6);
      return 32'(regs[1] | (pm & 2) << 5 | (regs[2] | (pm & 4) << 4) << 8);
   endfunction
   task automatic trial(int c, int t);
      int p, m, ix, fm, sts;
      logic [15:0] v;
      p = $urandom % 3;
      m = $urandom % 8;
      ix = pick(c);
      v = t ? 16'($urandom) : 16'hFFFF;
      if (ix >= 0) v[ix] = 1'(t);
      lat <= 3'(4 + $urandom % 4);
      bus(1'b1, 4'hC, 32'(m), 4'hF);
      regs[p] = ($urandom % 2) * 128 + 32 + c;
      d0 = dcnt;
      bus(1'b1, p ? 4'h4 : 4'h0, 32'(regs[p]) << (p / 2 * 8), p == 2 ? 4'h2 : 4'h1);
      `TRG <= v;
      @(posedge clock_i);
      `TRG <= 16'h0;
      fm = 0;
      for (int q = 0; q < 3; q++) begin
         ix = pick(regs[q] % 32);
         if ((q == p && c == 1) || (ix >= 0 && v[ix])) fm |= 1 << q;
         if (fm >> q & 1) regs[q] &= ~32;
      end
      bus(1'b0, p ? 4'h4 : 4'h0, 32'h0, 4'hF);
      `CHK("pending", ctrl(p, fm), rd)
      repeat (80) @(posedge clock_i);
      sts = 0;
      for (int q = 0; q < 3; q++) begin
         `CHK("conversions", d0[q] + (fm >> q & 1), dcnt[q])
         sts |= (fm >> q & 1) * (regs[q] >> 7 & 1) << q;
      end
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      `CHK("status", 32'(sts), rd)
      `CHK("irq", 1'((sts & m) != 0), irq_o)
      bus(1'b0, p ? 4'h4 : 4'h0, 32'h0, 4'hF);
      `CHK("done", ctrl(p, 0), rd)
      bus(1'b1, 4'h8, 32'h7, 4'hF);
      `CHK("irq clear", 1'b0, irq_o)
   endtask
   initial begin
      void'($urandom(32'hA75C804C));
      repeat (20) @(posedge clock_i);
      reset_i <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         bus(1'b0, 4'(k < 4 ? k * 4 : 2), 32'h0, 4'hF);
         `CHK("reset value", 32'h0, rd)
      end
      for (int q = 0; q < 3; q++) regs[q] = $urandom & 32'h9F;
      // Pending bits written as one must be ignored
      bus(1'b1, 4'h0, 32'($urandom & 32'hFFFFFF00 | regs[0] | 64), 4'h1);
      bus(1'b1, 4'h4, 32'(regs[1] | regs[2] << 8 | 32'h4040), 4'h3);
      bus(1'b1, 4'h2, 32'hFFFF, 4'hF);
      for (int k = 0; k < 2; k++) begin
         bus(1'b0, 4'(k * 4), 32'h0, 4'hF);
         `CHK("control", ctrl(k, 0), rd)
      end
      for (int c = 0; c < 32; c++) for (int t = 0; t < 2; t++) trial(c, t);
      stop_test();
   end
endmodule // test_adc_pair_trigger_control
